// File: include/mrs_params.svh
`ifndef MRS_PARAMS_SVH
`define MRS_PARAMS_SVH

// Processor mode select field values
`define MRS_MODE_SINGLE_CHIP 2'h0
`define MRS_MODE_MICRO       2'h3

// Reset cause codes
`define MRS_CAUSE_HW  2'h0
`define MRS_CAUSE_SW  2'h1
`define MRS_CAUSE_WDT 2'h2

// Cycles the pins stay in reset state after an internal reset request
`define MRS_INT_HOLD_CYC 8'h14
// Cycles spent initialising CPU and special function registers
`define MRS_INIT_CYC     8'h04

// Reset value of the watchdog reset select bit
`define MRS_WDT_SEL_RST 1'h0

`endif

// File: include/mrs_pkg.sv
package mrs_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        MRS_PIN_HOLD,
        MRS_INT_HOLD,
        MRS_INIT,
        MRS_FETCH,
        MRS_RUN
    } mrs_state_t;

endpackage

// File: core/mrs_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for asynchronous levels
module mrs_sync #(
    parameter int          WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;   // Metastable stage, read only by stage two

    // Both stages reset to the safe level
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

`default_nettype wire

// File: core/mrs_reset_ctrl.sv
// Overview of operation
// - Three reset sources: pin, software, watchdog
// - Pin low: pins to reset state, oscillator starts
// - Pin release: init CPU, registers, fetch vector
// - Internal RAM is never cleared by reset
// - Pin falling during RAM write: RAM indeterminate
// - Software request bit one forces internal reset
// - Software reset keeps processor mode bits
// - Watchdog underflow with select set resets
// - Watchdog reset keeps processor mode bits
// - Single-chip reset: ports input, last output
// - Bus-mode reset: strobes high, latch low, clock out
// - Bus-mode reset: hold acknowledge follows request
// - Bus-mode reset: spare selects input, pulled up
// - Pin states valid only once supply settled
`timescale 1ns/1ps
`default_nettype none

`include "mrs_params.svh"

module mrs_reset_ctrl
    import mrs_pkg::*;
#(
    parameter int NUM_PORTS = 12     // Ports P0 up to the last output port
) (
    input  wire logic                 clock,                 // 20 MHz main clock
    input  wire logic                 rst_n,                 // Logic power-on reset
    input  wire logic                 reset_pin_n,           // External reset pin
    input  wire logic                 supply_stable,         // Internal supply settled
    input  wire logic                 boot_mode_pin,         // High selects bus modes
    input  wire logic                 hold_request,          // Hold request pin
    input  wire logic                 software_reset_request_bit, // Write-one pulse
    input  wire logic                 mode_wr,               // Processor mode write
    input  wire logic [1:0]           mode_wdata,            // New mode select bits
    input  wire logic                 wdt_sel_wr,            // Select bit write
    input  wire logic                 wdt_sel_wdata,         // New select bit value
    input  wire logic                 watchdog_underflow,    // One-cycle pulse
    input  wire logic                 ram_write_active,      // RAM write in progress
    input  wire logic                 ram_flag_clear,        // Clears RAM flag
    output logic                      cpu_reset,             // CPU held in reset
    output logic                      sfr_init,              // Initialise registers
    output logic                      sfr_keep_mode,         // Partial init on internal
    output logic                      vector_fetch,          // Start at reset vector
    output logic                      osc_init,              // Oscillator reinitialise
    output logic [1:0]                reset_cause,           // Last reset source
    output logic                      ram_indeterminate,     // RAM contents suspect
    output logic                      processor_mode_sel_hi, // Mode select high bit
    output logic                      processor_mode_sel_lo, // Mode select low bit
    output logic                      watchdog_reset_select_bit, // Watchdog reset enable
    output logic                      pin_override,          // Pins in reset state
    output logic                      pins_valid,            // Pin states meaningful
    output logic [NUM_PORTS-1:0]      port_oe,               // Port direction override
    output logic                      chip_select_zero,      // Chip select zero level
    output logic                      write_strobe,          // Write strobe level
    output logic                      read_strobe,           // Read strobe level
    output logic                      addr_latch_enable,     // Address latch level
    output logic                      bus_clock,             // Bus clock output
    output logic                      bus_clock_oe,          // Bus clock driven
    output logic                      hold_acknowledge,      // Hold acknowledge level
    output logic [2:0]                spare_cs_pullup        // Spare select pull-ups
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisation

    logic       pin_n_s;        // Synchronised reset pin
    logic       supply_s;       // Synchronised supply flag
    logic       boot_s;         // Synchronised boot mode pin
    logic       hold_s;         // Synchronised hold request
    logic       pin_n_d;        // Delayed copy for edge detect

    // Pin and supply reset to the asserted side so nothing runs early
    mrs_sync #(.WIDTH(2), .RST_VAL(2'h0)) u_sync_rst (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in ({reset_pin_n, supply_stable}),
        .sync_out ({pin_n_s, supply_s})
    );

    mrs_sync #(.WIDTH(2), .RST_VAL(2'h0)) u_sync_pins (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in ({boot_mode_pin, hold_request}),
        .sync_out ({boot_s, hold_s})
    );

    // Edge detect on the synchronised stage only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_n_d <= 1'h0;
        end else begin
            pin_n_d <= pin_n_s;
        end
    end

    logic pin_low;              // Hardware reset in force
    logic pin_fall;             // Pin just went low
    logic int_req;              // Internal reset request

    assign pin_low  = !pin_n_s || !supply_s;
    assign pin_fall = pin_n_d && !pin_n_s;
    // Software requests assume a stable main clock
    assign int_req  = software_reset_request_bit
                   || (watchdog_underflow && watchdog_reset_select_bit);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    mrs_state_t state;          // Current state
    mrs_state_t next_state;     // Next state
    logic [7:0] count;          // Hold and init counter
    logic       count_done;     // Counter expired

    assign count_done = (count == 8'h00);

    // Pin reset wins over everything; internal requests only while running
    always_comb begin
        next_state = state;
        case (state)
            MRS_PIN_HOLD: begin
                if (!pin_low) begin
                    next_state = MRS_INIT;
                end
            end
            MRS_INT_HOLD: begin
                if (count_done) begin
                    next_state = MRS_INIT;
                end
            end
            MRS_INIT: begin
                if (count_done) begin
                    next_state = MRS_FETCH;
                end
            end
            MRS_FETCH: begin
                next_state = MRS_RUN;
            end
            MRS_RUN: begin
                if (int_req) begin
                    next_state = MRS_INT_HOLD;
                end
            end
            default: begin
                next_state = MRS_PIN_HOLD;
            end
        endcase
        if (pin_low) begin
            next_state = MRS_PIN_HOLD;
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= MRS_PIN_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // Counter loads on entry to each timed state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= 8'h00;
        end else if (next_state == MRS_INT_HOLD && state != MRS_INT_HOLD) begin
            count <= `MRS_INT_HOLD_CYC - 8'h01;
        end else if (next_state == MRS_INIT && state != MRS_INIT) begin
            count <= `MRS_INIT_CYC - 8'h01;
        end else if (!count_done) begin
            count <= count - 8'h01;
        end
    end

    // Cause register remembers which source fired
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reset_cause <= `MRS_CAUSE_HW;
        end else if (pin_low) begin
            reset_cause <= `MRS_CAUSE_HW;
        end else if (state == MRS_RUN && software_reset_request_bit) begin
            reset_cause <= `MRS_CAUSE_SW;
        end else if (state == MRS_RUN && int_req) begin
            reset_cause <= `MRS_CAUSE_WDT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Processor mode and watchdog select bits

    // Mode bits reload from the boot pin only on hardware reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            processor_mode_sel_hi <= 1'h0;
            processor_mode_sel_lo <= 1'h0;
        end else if (state == MRS_PIN_HOLD) begin
            {processor_mode_sel_hi, processor_mode_sel_lo} <=
                boot_s ? `MRS_MODE_MICRO : `MRS_MODE_SINGLE_CHIP;
        end else if (mode_wr && state == MRS_RUN) begin
            {processor_mode_sel_hi, processor_mode_sel_lo} <= mode_wdata;
        end
        // Internal resets leave the bits untouched
    end

    // Select bit clears on any reset, writable while running
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_reset_select_bit <= `MRS_WDT_SEL_RST;
        end else if (state == MRS_PIN_HOLD || state == MRS_INT_HOLD) begin
            watchdog_reset_select_bit <= `MRS_WDT_SEL_RST;
        end else if (wdt_sel_wr && state == MRS_RUN) begin
            watchdog_reset_select_bit <= wdt_sel_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // RAM integrity flag

    // No RAM clear is ever issued, contents survive resets
    // Set beats clear in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ram_indeterminate <= 1'h0;
        end else if (pin_fall && ram_write_active) begin
            ram_indeterminate <= 1'h1;
        end else if (ram_flag_clear) begin
            ram_indeterminate <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // CPU side controls, registered

    // Outputs except pins_valid registered from next_state so they change with the state, glitch free
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cpu_reset     <= 1'h1;
            sfr_init      <= 1'h0;
            sfr_keep_mode <= 1'h0;
            vector_fetch  <= 1'h0;
            osc_init      <= 1'h1;
            pin_override  <= 1'h1;
            pins_valid    <= 1'h0;
        end else begin
            cpu_reset     <= (next_state != MRS_RUN);
            sfr_init      <= (next_state == MRS_INIT);
            sfr_keep_mode <= (next_state == MRS_INIT)
                          && (reset_cause != `MRS_CAUSE_HW);
            vector_fetch  <= (next_state == MRS_FETCH);
            osc_init      <= (next_state == MRS_PIN_HOLD);
            pin_override  <= (next_state == MRS_PIN_HOLD)
                          || (next_state == MRS_INT_HOLD);
            pins_valid    <= supply_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin reset states

    logic bus_mode;             // External bus mode selected
    assign bus_mode = ({processor_mode_sel_hi, processor_mode_sel_lo}
                       != `MRS_MODE_SINGLE_CHIP);

    // Direction: only the last port drives, in every mode and state
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    port_oe[gi] <= (gi == NUM_PORTS - 1);
                end else begin
                    port_oe[gi] <= (gi == NUM_PORTS - 1);
                end
            end
        end
    endgenerate

    // Bus strobe levels held idle in bus mode
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            chip_select_zero  <= 1'h1;
            write_strobe      <= 1'h1;
            read_strobe       <= 1'h1;
            addr_latch_enable <= 1'h0;
            hold_acknowledge  <= 1'h0;
            spare_cs_pullup   <= 3'h0;
            bus_clock_oe      <= 1'h0;
        end else begin
            chip_select_zero  <= 1'h1;
            write_strobe      <= 1'h1;
            read_strobe       <= 1'h1;
            addr_latch_enable <= 1'h0;
            hold_acknowledge  <= bus_mode && hold_s;
            spare_cs_pullup   <= {3{bus_mode}};
            bus_clock_oe      <= bus_mode;
        end
    end

    // Bus clock is the main clock halved, free running
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_clock <= 1'h0;
        end else begin
            bus_clock <= !bus_clock;
        end
    end

endmodule

`default_nettype wire

// File: testbench/mrs_reset_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "mrs_params.svh"

// Port-level checker for the reset sequencer
module mrs_reset_ctrl_monitor
    import mrs_pkg::*;
#(
    parameter int NUM_PORTS = 12
) (
    input wire logic                 clock,
    input wire logic                 rst_n,
    input wire logic                 reset_pin_n,
    input wire logic                 software_reset_request_bit,
    input wire logic                 watchdog_underflow,
    input wire logic                 cpu_reset,
    input wire logic                 sfr_init,
    input wire logic                 sfr_keep_mode,
    input wire logic                 vector_fetch,
    input wire logic                 osc_init,
    input wire logic [1:0]           reset_cause,
    input wire logic                 processor_mode_sel_hi,
    input wire logic                 processor_mode_sel_lo,
    input wire logic                 watchdog_reset_select_bit,
    input wire logic                 pin_override,
    input wire logic [NUM_PORTS-1:0] port_oe,
    input wire logic                 chip_select_zero,
    input wire logic                 write_strobe,
    input wire logic                 read_strobe,
    input wire logic                 addr_latch_enable,
    input wire logic                 bus_clock,
    input wire logic                 bus_clock_oe,
    input wire logic                 hold_acknowledge,
    input wire logic [2:0]           spare_cs_pullup
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Accepted requests; simultaneous sources left out, priority is open
    wire logic sw_go = software_reset_request_bit && !watchdog_underflow && !cpu_reset;
    wire logic wd_go = watchdog_underflow && watchdog_reset_select_bit
                       && !software_reset_request_bit && !cpu_reset;
    ////////////////////////////////////////////////////////////////
    // Init phase, then vector fetch, then run
    sequence s_init4;
        sfr_init [*4];
    endsequence
    sequence s_fetch;
        (vector_fetch && !sfr_init) ##1 !cpu_reset;
    endsequence
    a_init_then_fetch: assert property ($rose(sfr_init) |-> s_init4 ##1 s_fetch)
        else $error("init or fetch timing wrong");
    a_sw_reset_seq: assert property (sw_go |=> (cpu_reset && pin_override
        && reset_cause == `MRS_CAUSE_SW) ##20 (sfr_init && sfr_keep_mode && !pin_override))
        else $error("software reset sequence wrong");
    a_wdt_reset_seq: assert property (wd_go |=> (cpu_reset && pin_override
        && reset_cause == `MRS_CAUSE_WDT) ##20 (sfr_init && sfr_keep_mode))
        else $error("watchdog reset sequence wrong");
    a_wdt_off_ignored: assert property ((watchdog_underflow && !watchdog_reset_select_bit
        && !software_reset_request_bit && !cpu_reset) |=> !cpu_reset)
        else $error("watchdog reset taken while disabled");
    a_mode_kept: assert property ((sw_go || wd_go) |=> ##20
        ({processor_mode_sel_hi, processor_mode_sel_lo}
         == $past({processor_mode_sel_hi, processor_mode_sel_lo}, 21)))
        else $error("mode bits lost over internal reset");
    a_bus_strobes: assert property (pin_override |-> (chip_select_zero && write_strobe
        && read_strobe && !addr_latch_enable)) else $error("bus strobes wrong in reset");
    a_bus_clock_runs: assert property ((pin_override && bus_clock_oe && $past(bus_clock_oe))
        |-> bus_clock != $past(bus_clock)) else $error("bus clock stuck in reset");
    a_spare_pullup: assert property (pin_override |-> (spare_cs_pullup == {3{bus_clock_oe}}
        && (bus_clock_oe || !hold_acknowledge))) else $error("spare selects or hold wrong");
    a_ports_input: assert property (pin_override |-> port_oe == {1'b1, {(NUM_PORTS-1){1'b0}}})
        else $error("port directions wrong in reset");
    a_osc_in_hold: assert property (osc_init |-> (cpu_reset && pin_override))
        else $error("oscillator init outside pin hold");
    a_pin_synced: assert property (($rose(reset_pin_n) && osc_init) |-> ##1 !sfr_init [*2])
        else $error("pin release not synchronised");
endmodule
`default_nettype wire

// File: testbench/mrs_reset_source.sv
`timescale 1ns/1ps
`default_nettype none

// External reset circuit: power-on ramp, then pin resets on demand
module mrs_reset_source #(
    parameter int SETTLE = 8            // Supply settle cycles
) (
    input  wire logic       clock,
    input  wire logic       go,         // Request one pin reset
    input  wire logic [7:0] low_len,    // Extra low cycles beyond 20
    output logic            reset_pin_n,
    output logic            supply_stable
);
    int hold;                           // Extra low time of this reset
    initial begin
        hold = 0;
        reset_pin_n = 1'b0;             // Low while supply rises
        supply_stable = 1'b0;
        repeat (SETTLE) @(negedge clock);
        supply_stable = 1'b1;           // Settle time over
        forever begin
            repeat (20 + hold) @(negedge clock); // At least 20 clocks low
            reset_pin_n = 1'b1;
            @(posedge clock iff go);
            @(negedge clock);
            hold = int'(low_len);
            reset_pin_n = 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: testbench/mrs_reset_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "mrs_params.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end

module mrs_reset_ctrl_test;
    import mrs_pkg::*;
    localparam int NUM_PORTS = 12;
    logic clock = 0, rst_n = 0, boot_mode_pin = 1, hold_request = 0, go = 0;
    logic software_reset_request_bit = 0, mode_wr = 0, wdt_sel_wr = 0, wdt_sel_wdata = 0;
    logic watchdog_underflow = 0, ram_write_active = 0, ram_flag_clear = 0;
    logic [1:0] mode_wdata = 2'h0;
    logic [7:0] low_len = 8'h00;
    logic reset_pin_n, supply_stable, cpu_reset, sfr_init, sfr_keep_mode, vector_fetch;
    logic osc_init, ram_indeterminate, processor_mode_sel_hi, processor_mode_sel_lo;
    logic watchdog_reset_select_bit, pin_override, pins_valid, chip_select_zero;
    logic write_strobe, read_strobe, addr_latch_enable, bus_clock, bus_clock_oe;
    logic hold_acknowledge;
    logic [1:0] reset_cause;
    logic [2:0] spare_cs_pullup;
    logic [NUM_PORTS-1:0] port_oe;
    int mismatches = 0, num_checks = 0;
    logic [31:0] seed = 32'he2f4;       // Fixed seed keeps runs repeatable

    always #25 clock = ~clock;

    mrs_reset_ctrl #(.NUM_PORTS(NUM_PORTS)) i_mrs_reset_ctrl (
        .clock(clock), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
        .supply_stable(supply_stable), .boot_mode_pin(boot_mode_pin),
        .hold_request(hold_request), .software_reset_request_bit(software_reset_request_bit),
        .mode_wr(mode_wr), .mode_wdata(mode_wdata), .wdt_sel_wr(wdt_sel_wr),
        .wdt_sel_wdata(wdt_sel_wdata), .watchdog_underflow(watchdog_underflow),
        .ram_write_active(ram_write_active), .ram_flag_clear(ram_flag_clear),
        .cpu_reset(cpu_reset), .sfr_init(sfr_init), .sfr_keep_mode(sfr_keep_mode),
        .vector_fetch(vector_fetch), .osc_init(osc_init), .reset_cause(reset_cause),
        .ram_indeterminate(ram_indeterminate), .processor_mode_sel_hi(processor_mode_sel_hi),
        .processor_mode_sel_lo(processor_mode_sel_lo),
        .watchdog_reset_select_bit(watchdog_reset_select_bit), .pin_override(pin_override),
        .pins_valid(pins_valid), .port_oe(port_oe), .chip_select_zero(chip_select_zero),
        .write_strobe(write_strobe), .read_strobe(read_strobe),
        .addr_latch_enable(addr_latch_enable), .bus_clock(bus_clock),
        .bus_clock_oe(bus_clock_oe), .hold_acknowledge(hold_acknowledge),
        .spare_cs_pullup(spare_cs_pullup));
    mrs_reset_source i_mrs_reset_source (.clock(clock), .go(go), .low_len(low_len),
        .reset_pin_n(reset_pin_n), .supply_stable(supply_stable));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Mode bits a pin reset loads from the boot pin
    function automatic logic [1:0] exp_mode(logic boot);
        return boot ? `MRS_MODE_MICRO : `MRS_MODE_SINGLE_CHIP;
    endfunction
    // Cycles cpu_reset stays high after an internal request
    function automatic int exp_busy();
        return int'(`MRS_INT_HOLD_CYC) + int'(`MRS_INIT_CYC) + 1;
    endfunction
    task automatic tick(int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Wait for run, counting reset and init cycles; bounded
    task automatic wait_run(output int busy, output int inits);
        int k;
        busy = 0;
        inits = 0;
        for (k = 0; k < 300 && (busy == 0 || cpu_reset !== 1'b0); k++) begin
            busy += int'(cpu_reset === 1'b1);
            inits += int'(sfr_init === 1'b1);
            tick(1);
        end
        if (k == 300) begin
            mismatches++;
            $display("CHECK FAILED run exp 1 got 0");
            give_verdict();
        end
    endtask
    // Pin reset with chosen boot mode and RAM write state
    task automatic pin_reset(logic b, logic r);
        int busy, inits;
        boot_mode_pin = b;
        hold_request = 1'b1;
        ram_write_active = r;
        low_len = 8'(xorshift() % 16);
        go = 1'b1;
        tick(1);
        go = 1'b0;
        tick(12);
        `CHK("hold ack", b, hold_acknowledge);
        `CHK("spare pullup", {3{b}}, spare_cs_pullup);
        `CHK("bus clock oe", b, bus_clock_oe);
        `CHK("osc init", 1'b1, osc_init);
        `CHK("port oe", {1'b1, {(NUM_PORTS-1){1'b0}}}, port_oe);
        `CHK("pins valid", 1'b1, pins_valid);
        hold_request = 1'b0;
        tick(5);
        `CHK("hold ack low", 1'b0, hold_acknowledge);
        ram_write_active = 1'b0;
        wait_run(busy, inits);
        `CHK("ram flag", r, ram_indeterminate);
        `CHK("mode", exp_mode(b), {processor_mode_sel_hi, processor_mode_sel_lo});
        `CHK("cause", `MRS_CAUSE_HW, reset_cause);
        ram_flag_clear = 1'b1;
        tick(1);
        ram_flag_clear = 1'b0;
        tick(1);
        `CHK("ram flag clear", 1'b0, ram_indeterminate);
        $display("test pin_reset done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        int busy, inits;
        logic [1:0] m;
        logic wd;
        tick(5);
        rst_n = 1'b1;
        // Power-on release in bus mode
        wait_run(busy, inits);
        `CHK("cause", `MRS_CAUSE_HW, reset_cause);
        `CHK("init cycles", int'(`MRS_INIT_CYC), inits);
        `CHK("mode", exp_mode(1'b1), {processor_mode_sel_hi, processor_mode_sel_lo});
        `CHK("wdt sel", `MRS_WDT_SEL_RST, watchdog_reset_select_bit);
        // Underflow with select clear must be ignored
        watchdog_underflow = 1'b1;
        tick(1);
        watchdog_underflow = 1'b0;
        tick(3);
        `CHK("no wdt reset", 1'b0, cpu_reset);
        $display("test power_on done");
        // Random internal resets with random mode bits
        for (int i = 0; i < 6; i++) begin
            m = 2'(xorshift());
            wd = i[0];
            hold_request = ^xorshift();
            ram_write_active = ^xorshift();
            mode_wdata = m;
            mode_wr = 1'b1;
            tick(1);
            mode_wr = 1'b0;
            wdt_sel_wdata = wd;
            wdt_sel_wr = 1'b1;
            tick(1);
            wdt_sel_wr = 1'b0;
            tick(int'(xorshift() % 5));
            `CHK("wdt sel set", wd, watchdog_reset_select_bit);
            // Main clock runs throughout, so a software request is legal
            if (wd)
                watchdog_underflow = 1'b1;
            else
                software_reset_request_bit = 1'b1;
            tick(1);
            watchdog_underflow = 1'b0;
            software_reset_request_bit = 1'b0;
            wait_run(busy, inits);
            `CHK("cause", wd ? `MRS_CAUSE_WDT : `MRS_CAUSE_SW, reset_cause);
            `CHK("busy cycles", exp_busy(), busy);
            `CHK("mode kept", m, {processor_mode_sel_hi, processor_mode_sel_lo});
            `CHK("wdt sel cleared", 1'b0, watchdog_reset_select_bit);
            `CHK("ram flag", 1'b0, ram_indeterminate);
        end
        ram_write_active = 1'b0;
        $display("test internal_resets done");
        // Pin resets: single-chip with RAM write, then bus mode
        pin_reset(1'b0, 1'b1);
        pin_reset(1'b1, 1'b0);
        give_verdict();
    end
endmodule

bind mrs_reset_ctrl mrs_reset_ctrl_monitor #(.NUM_PORTS(NUM_PORTS)) i_mrs_reset_ctrl_monitor (
    .clock(clock), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
    .software_reset_request_bit(software_reset_request_bit),
    .watchdog_underflow(watchdog_underflow), .cpu_reset(cpu_reset), .sfr_init(sfr_init),
    .sfr_keep_mode(sfr_keep_mode), .vector_fetch(vector_fetch), .osc_init(osc_init),
    .reset_cause(reset_cause), .processor_mode_sel_hi(processor_mode_sel_hi),
    .processor_mode_sel_lo(processor_mode_sel_lo),
    .watchdog_reset_select_bit(watchdog_reset_select_bit), .pin_override(pin_override),
    .port_oe(port_oe), .chip_select_zero(chip_select_zero), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .addr_latch_enable(addr_latch_enable), .bus_clock(bus_clock),
    .bus_clock_oe(bus_clock_oe), .hold_acknowledge(hold_acknowledge),
    .spare_cs_pullup(spare_cs_pullup));
`default_nettype wire
